// >>> hdl/vpim_image_map.sv
// Purpose: process image map between fieldbus side and valve modules
// Assumes: module inputs, diag bytes and paramLost are on core_clk
// Notes: APB slave, one wait state on every access
`timescale 1ns/1ps
module vpim_image_map (
  // clock and reset
  input  wire logic                                 core_clk,
  input  wire logic                                 resetn,
  // register bus
  input  wire vpim_pkg::vpim_apb_req_t              apbReq,
  output vpim_pkg::vpim_apb_rsp_t                   apbRsp,
  // module inputs
  input  wire logic [vpim_pkg::IN_MOD_WORDS-1:1][15:0] modInWords,
  input  wire logic [vpim_pkg::DIAG_BYTES-1:0][7:0]    diagBytes,
  input  wire logic                                 paramLost,
  // module outputs
  output logic [vpim_pkg::OUT_MOD_WORDS-1:1][15:0]  driveWords,
  output logic [15:0]                               activeParam,
  output logic                                      paramAck,
  output logic                                      irq
);
  vpim_pkg::vpim_map_state_t                 stQ;
  vpim_pkg::vpim_map_state_t                 stD;
  logic [vpim_pkg::IN_WORDS-1:0][15:0]       inImg;
  logic                                      run;
  logic                                      swap;
  logic                                      xferRise;
  logic                                      access;
  logic                                      done;
  logic                                      rdStart;
  logic                                      wrDone;
  logic                                      hit;
  logic [31:0]                               rd;
  logic [3:0]                                oIdx;
  logic [3:0]                                iIdx;
  logic [15:0]                               modWord;
  logic [vpim_pkg::STS_W-1:0]                clr;
  logic [vpim_pkg::STS_W-1:0]                stsSet;
  logic [11:0]                               addr;

  assign addr     = apbReq.paddr;
  assign access   = apbReq.psel & apbReq.penable;
  assign done     = access & stQ.ready;
  assign rdStart  = access & ~stQ.ready & ~apbReq.pwrite;
  assign wrDone   = done & apbReq.pwrite;
  assign run      = stQ.outImg[0][vpim_pkg::RUN_BIT];
  assign swap     = stQ.actParam[vpim_pkg::SWAP_BIT];
  assign xferRise = stQ.outImg[0][vpim_pkg::XFER_BIT] & ~stQ.prevXfer;
  assign oIdx     = 4'((addr - vpim_pkg::OUT_BASE) >> 2);
  assign iIdx     = 4'((addr - vpim_pkg::IN_BASE) >> 2);

  // input image assembly
  always_comb begin
    inImg = '0;
    modWord = 16'h0000;
    inImg[0][vpim_pkg::ACK_BIT] = stQ.ack;
    for (int i = 1; i < vpim_pkg::IN_MOD_WORDS; i++) begin
      modWord = modInWords[i] & vpim_pkg::infoMask(vpim_pkg::IN_KIND[i], 0);
      if (vpim_pkg::IN_KIND[i] == vpim_pkg::KIND_WORD && swap) begin
        modWord = {modWord[7:0], modWord[15:8]};
      end
      inImg[i] = modWord;
    end
    for (int d = 0; d < vpim_pkg::DIAG_WORDS; d++) begin
      inImg[vpim_pkg::IN_MOD_WORDS + d] = {diagBytes[2 * d + 1], diagBytes[2 * d]};
    end
  end

  // register read decode
  always_comb begin
    rd = 32'h0000_0000;
    hit = 1'b1;
    if (addr[1:0] != 2'h0) begin
      hit = 1'b0;
    end else if (addr >= vpim_pkg::OUT_BASE && addr < vpim_pkg::OUT_END) begin
      rd = {16'h0000, stQ.outImg[oIdx]};
    end else if (addr >= vpim_pkg::IN_BASE && addr < vpim_pkg::IN_END) begin
      rd = {16'h0000, inImg[iIdx]};
    end else if (addr == vpim_pkg::STS_OFS) begin
      rd = {29'h0, stQ.sts};
    end else if (addr == vpim_pkg::CLR_OFS) begin
      rd = 32'h0000_0000;
    end else if (addr == vpim_pkg::EN_OFS) begin
      rd = {29'h0, stQ.en};
    end else if (addr == vpim_pkg::ACT_OFS) begin
      rd = {16'h0000, stQ.actParam};
    end else begin
      hit = 1'b0;
    end
  end

  // next state
  always_comb begin
    stD = stQ;
    clr = '0;
    stsSet = '0;
    stD.ready = access & ~stQ.ready;
    stD.prevXfer = stQ.outImg[0][vpim_pkg::XFER_BIT];
    stD.prevRun = run;
    if (access && !stQ.ready) begin
      stD.slverr = ~hit;
      stD.rdata = (hit && !apbReq.pwrite) ? rd : 32'h0000_0000;
    end
    if (done && apbReq.pwrite && hit) begin
      if (addr < vpim_pkg::OUT_END) begin
        stD.outImg[oIdx] = apbReq.pwdata[15:0] & vpim_pkg::outMask(int'(oIdx));
      end else if (addr == vpim_pkg::CLR_OFS) begin
        clr = apbReq.pwdata[vpim_pkg::STS_W-1:0];
      end else if (addr == vpim_pkg::EN_OFS) begin
        stD.en = apbReq.pwdata[vpim_pkg::STS_W-1:0];
      end
    end
    if (paramLost) begin
      stD.ack = 1'b0;
      stD.actParam = vpim_pkg::WORD_RST;
      stsSet[vpim_pkg::STS_LOST] = 1'b1;
    end else if (xferRise) begin
      stD.actParam = stQ.outImg[vpim_pkg::PARAM_IDX] & vpim_pkg::PARAM_MASK;
      stD.ack = 1'b1;
      stsSet[vpim_pkg::STS_TAKEN] = 1'b1;
    end
    stsSet[vpim_pkg::STS_RUN] = run ^ stQ.prevRun;
    stD.sts = (stQ.sts & ~clr) | stsSet;
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      stQ <= '0;
    end else begin
      stQ <= stD;
    end
  end

  // module output lanes
  genvar g;
  generate
    for (g = 1; g < vpim_pkg::OUT_MOD_WORDS; g++) begin : gLane
      vpim_word_lane #(
        .KIND   (vpim_pkg::OUT_KIND[g]),
        .VALVES (vpim_pkg::OUT_VALVES[g])
      ) uLane (
        .core_clk  (core_clk),
        .resetn    (resetn),
        .rawWord   (stQ.outImg[g]),
        .run       (run),
        .swap      (swap),
        .driveWord (driveWords[g])
      );
    end
  endgenerate

  assign apbRsp.pready  = stQ.ready;
  assign apbRsp.pslverr = stQ.ready & stQ.slverr;
  assign apbRsp.prdata  = stQ.rdata;
  assign activeParam    = stQ.actParam;
  assign paramAck       = stQ.ack;
  assign irq            = |(stQ.sts & stQ.en);

  a_param_take: assert property (@(posedge core_clk) disable iff (!resetn)
    xferRise && !paramLost |=> paramAck
      && activeParam == ($past(stQ.outImg[vpim_pkg::PARAM_IDX]) & vpim_pkg::PARAM_MASK))
    else $error("parameters not taken on transfer flag");

  a_param_only_flag: assert property (@(posedge core_clk) disable iff (!resetn)
    !xferRise && !paramLost |=> $stable(activeParam))
    else $error("parameters changed without transfer flag");

  a_ack_held: assert property (@(posedge core_clk) disable iff (!resetn)
    paramAck && !paramLost |=> paramAck)
    else $error("acknowledge dropped without parameter loss");

  a_lost_clears: assert property (@(posedge core_clk) disable iff (!resetn)
    paramLost |=> !paramAck && activeParam == 16'h0000 && stQ.sts[vpim_pkg::STS_LOST])
    else $error("lost parameters still acknowledged");

  a_param_slot: assert property (@(posedge core_clk) disable iff (!resetn)
    access && !stQ.ready && !apbReq.pwrite
      && addr == vpim_pkg::OUT_BASE + 12'(4 * (vpim_pkg::OUT_WORDS - 1))
      |=> apbRsp.pready && apbRsp.prdata[15:0] == stQ.outImg[vpim_pkg::OUT_MOD_WORDS])
    else $error("parameter word not in last output slot");

  a_diag_slot: assert property (@(posedge core_clk) disable iff (!resetn)
    access && !stQ.ready && !apbReq.pwrite
      && addr == vpim_pkg::IN_BASE + 12'(4 * vpim_pkg::IN_MOD_WORDS)
      |=> apbRsp.pready && apbRsp.prdata == {16'h0000, $past(diagBytes[1]),
      $past(diagBytes[0])})
    else $error("first diagnostic word misplaced");

  a_ctrl_clean: assert property (@(posedge core_clk) disable iff (!resetn)
    (stQ.outImg[0] & ~vpim_pkg::CTRL_MASK) == 16'h0000
      && (stQ.outImg[vpim_pkg::PARAM_IDX] & ~vpim_pkg::PARAM_MASK) == 16'h0000)
    else $error("non-information bit stored");

  a_ack_word_clean: assert property (@(posedge core_clk) disable iff (!resetn)
    inImg[0] == {15'h0000, paramAck})
    else $error("status word carries stray bits");

  a_answer_next: assert property (@(posedge core_clk) disable iff (!resetn)
    access && !stQ.ready |=> apbRsp.pready ##1 !apbRsp.pready)
    else $error("bus answer not after one wait state");

  a_out_len_end: assert property (@(posedge core_clk) disable iff (!resetn)
    access && !stQ.ready && addr == vpim_pkg::OUT_END |=> apbRsp.pslverr)
    else $error("access past output image accepted");

  a_diag_len_end: assert property (@(posedge core_clk) disable iff (!resetn)
    access && !stQ.ready && addr == vpim_pkg::IN_END |=> apbRsp.pslverr)
    else $error("access past diagnostic words accepted");

  a_out_word_store: assert property (@(posedge core_clk) disable iff (!resetn)
    wrDone && addr == vpim_pkg::OUT_BASE + 12'h004
      |=> stQ.outImg[1] == ($past(apbReq.pwdata[15:0]) & vpim_pkg::outMask(1)))
    else $error("output word not stored in its own slot");

  a_in_word_order: assert property (@(posedge core_clk) disable iff (!resetn)
    rdStart && addr == vpim_pkg::IN_BASE + 12'h004 && !swap
      |=> apbRsp.prdata == {16'h0000, $past(modInWords[1])})
    else $error("input word not in module order");

  a_in_word_swap: assert property (@(posedge core_clk) disable iff (!resetn)
    rdStart && addr == vpim_pkg::IN_BASE + 12'h004 && swap
      |=> apbRsp.prdata == {16'h0000, $past(modInWords[1][7:0]),
      $past(modInWords[1][15:8])})
    else $error("16-bit input value not byte swapped");

  a_in_byte_pad: assert property (@(posedge core_clk) disable iff (!resetn)
    rdStart && (addr == vpim_pkg::IN_BASE + 12'h008 || addr == vpim_pkg::IN_BASE + 12'h00c)
      |=> apbRsp.prdata[31:8] == 24'h000000)
    else $error("byte module input not padded to a word");

  a_ack_word_read: assert property (@(posedge core_clk) disable iff (!resetn)
    rdStart && addr == vpim_pkg::IN_BASE
      |=> apbRsp.prdata == {31'h00000000, $past(paramAck)})
    else $error("acknowledge not read in input word 0");

  a_act_read: assert property (@(posedge core_clk) disable iff (!resetn)
    rdStart && addr == vpim_pkg::ACT_OFS
      |=> apbRsp.prdata == {16'h0000, $past(activeParam)})
    else $error("active parameter read wrong");

  a_taken_sts: assert property (@(posedge core_clk) disable iff (!resetn)
    xferRise && !paramLost |=> stQ.sts[vpim_pkg::STS_TAKEN])
    else $error("parameter take not flagged in status");

  a_run_sts: assert property (@(posedge core_clk) disable iff (!resetn)
    run != stQ.prevRun |=> stQ.sts[vpim_pkg::STS_RUN])
    else $error("run flag change not flagged in status");

  a_sts_sticky: assert property (@(posedge core_clk) disable iff (!resetn)
    stQ.sts[vpim_pkg::STS_LOST] && !clr[vpim_pkg::STS_LOST] |=> stQ.sts[vpim_pkg::STS_LOST])
    else $error("status bit dropped without clear");

  a_en_store: assert property (@(posedge core_clk) disable iff (!resetn)
    wrDone && addr == vpim_pkg::EN_OFS
      |=> stQ.en == $past(apbReq.pwdata[vpim_pkg::STS_W-1:0]))
    else $error("enable write not stored");

  a_clr_reads_zero: assert property (@(posedge core_clk) disable iff (!resetn)
    rdStart && addr == vpim_pkg::CLR_OFS
      |=> apbRsp.prdata == 32'h0000_0000 && !apbRsp.pslverr)
    else $error("clear register read not zero");

  a_bad_write_ignored: assert property (@(posedge core_clk) disable iff (!resetn)
    wrDone && !hit |=> $stable(stQ.outImg) && $stable(stQ.en))
    else $error("refused write changed a register");

  a_in_write_ignored: assert property (@(posedge core_clk) disable iff (!resetn)
    wrDone && addr >= vpim_pkg::IN_BASE && addr < vpim_pkg::IN_END |=> $stable(stQ.outImg))
    else $error("write to input image changed output image");

  a_rdata_hold: assert property (@(posedge core_clk) disable iff (!resetn)
    !access |=> $stable(apbRsp.prdata))
    else $error("read data changed outside an access");

  a_ready_pulse: assert property (@(posedge core_clk) disable iff (!resetn)
    apbRsp.pready |=> !apbRsp.pready)
    else $error("ready held longer than one cycle");

  a_err_with_ready: assert property (@(posedge core_clk) disable iff (!resetn)
    apbRsp.pslverr |-> apbRsp.pready)
    else $error("error flag shown without ready");

  a_param_clean: assert property (@(posedge core_clk) disable iff (!resetn)
    (activeParam & ~vpim_pkg::PARAM_MASK) == 16'h0000)
    else $error("active parameter carries stray bits");

  a_drive_run_low: assert property (@(posedge core_clk) disable iff (!resetn)
    !run |=> driveWords == '0)
    else $error("module output active while run flag clear");

  c_param_take: cover property (@(posedge core_clk) disable iff (!resetn)
    xferRise && !paramLost ##1 paramAck);

  c_param_lost: cover property (@(posedge core_clk) disable iff (!resetn)
    paramAck ##1 paramLost);

  c_run_on: cover property (@(posedge core_clk) disable iff (!resetn)
    !run ##1 run ##2 driveWords[1] != 16'h0000);

  c_irq_seen: cover property (@(posedge core_clk) disable iff (!resetn)
    !irq ##1 irq);
endmodule

// >>> include/vpim_pkg.sv
// Purpose: constants and types for the valve process image map
// Assumes: one fixed module layout, one clock, APB register access
// Notes: output word i at OUT_BASE+4*i, input word i at IN_BASE+4*i
// How it works
// - run flag, output word 0 bit 1, lets output payload reach modules
// - parameters are taken only when transfer flag, word 0 bit 0, rises
// - coupler parameter word sits right after last module output word
// - output image length is module words plus one parameter word
// - four diagnostic words, eight bytes, follow the module input words
// - non-information bits are stored and presented as zero
// - word order fixed by physical module order, never reordered
// - valve word: two bits per valve, even sol 14, odd sol 12
// - every module starts on its own word, short data padded with zeros
// - input word 0 bit 0 acknowledges parameters, cleared when they are lost
// - parameter bit 3 picks big-endian (0) or little-endian (1) 16-bit values
package vpim_pkg;
  localparam int OUT_MOD_WORDS = 10;
  localparam int PARAM_WORDS   = 1;
  localparam int OUT_WORDS     = OUT_MOD_WORDS + PARAM_WORDS;
  localparam int PARAM_IDX     = OUT_WORDS - 1;
  localparam int IN_MOD_WORDS  = 4;
  localparam int DIAG_BYTES    = 8;
  localparam int DIAG_WORDS    = DIAG_BYTES / 2;
  localparam int IN_WORDS      = IN_MOD_WORDS + DIAG_WORDS;

  localparam int XFER_BIT = 0;
  localparam int RUN_BIT  = 1;
  localparam int ACK_BIT  = 0;
  localparam int SWAP_BIT = 3;

  localparam logic [15:0] CTRL_MASK  = 16'h0003;
  localparam logic [15:0] PARAM_MASK = 16'h000c;
  localparam logic [15:0] BYTE_MASK  = 16'h00ff;
  localparam logic [15:0] WORD_MASK  = 16'hffff;
  localparam logic [15:0] WORD_RST   = 16'h0000;

  localparam logic [11:0] OUT_BASE = 12'h000;
  localparam logic [11:0] OUT_END  = OUT_BASE + 12'(4 * OUT_WORDS);
  localparam logic [11:0] IN_BASE  = 12'h040;
  localparam logic [11:0] IN_END   = IN_BASE + 12'(4 * IN_WORDS);
  localparam logic [11:0] STS_OFS  = 12'h080;
  localparam logic [11:0] CLR_OFS  = 12'h084;
  localparam logic [11:0] EN_OFS   = 12'h088;
  localparam logic [11:0] ACT_OFS  = 12'h08c;

  localparam int STS_W     = 3;
  localparam int STS_TAKEN = 0;
  localparam int STS_LOST  = 1;
  localparam int STS_RUN   = 2;

  typedef enum logic [1:0] {
    KIND_CTRL  = 2'h0,
    KIND_VALVE = 2'h1,
    KIND_BYTE  = 2'h2,
    KIND_WORD  = 2'h3
  } vpim_kind_t;

  localparam vpim_kind_t OUT_KIND [OUT_MOD_WORDS] = '{KIND_CTRL, KIND_VALVE, KIND_VALVE,
    KIND_VALVE, KIND_VALVE, KIND_WORD, KIND_VALVE, KIND_VALVE, KIND_VALVE, KIND_BYTE};
  localparam int OUT_VALVES [OUT_MOD_WORDS] = '{0, 4, 2, 3, 4, 0, 4, 4, 3, 0};
  localparam vpim_kind_t IN_KIND [IN_MOD_WORDS] = '{KIND_CTRL, KIND_WORD, KIND_BYTE,
    KIND_BYTE};

  function automatic logic [15:0] infoMask(vpim_kind_t k, int n);
    logic [16:0] v;
    v = (17'h00001 << (2 * n)) - 17'h00001;
    unique case (k)
      KIND_VALVE: infoMask = v[15:0] & BYTE_MASK;
      KIND_BYTE:  infoMask = BYTE_MASK;
      KIND_WORD:  infoMask = WORD_MASK;
      KIND_CTRL:  infoMask = CTRL_MASK;
    endcase
  endfunction

  function automatic logic [15:0] outMask(int i);
    if (i == PARAM_IDX) begin
      outMask = PARAM_MASK;
    end else begin
      outMask = infoMask(OUT_KIND[i], OUT_VALVES[i]);
    end
  endfunction

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } vpim_apb_req_t;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } vpim_apb_rsp_t;

  typedef struct packed {
    logic [15:0] drive;
  } vpim_lane_state_t;

  typedef struct packed {
    logic [OUT_WORDS-1:0][15:0] outImg;
    logic [15:0]                actParam;
    logic                       ack;
    logic                       prevXfer;
    logic                       prevRun;
    logic [STS_W-1:0]           sts;
    logic [STS_W-1:0]           en;
    logic                       ready;
    logic                       slverr;
    logic [31:0]                rdata;
  } vpim_map_state_t;
endpackage

// >>> hdl/vpim_word_lane.sv
// Purpose: drive one module output word from its image word
// Assumes: run and swap come from logic on core_clk
// Notes: output registered, zero while run is low
`timescale 1ns/1ps
module vpim_word_lane #(
  parameter vpim_pkg::vpim_kind_t KIND   = vpim_pkg::KIND_BYTE,
  parameter int                   VALVES = 0
) (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        resetn,
  // image side
  input  wire logic [15:0] rawWord,
  input  wire logic        run,
  input  wire logic        swap,
  // module side
  output logic      [15:0] driveWord
);
  localparam logic [15:0] MASK = vpim_pkg::infoMask(KIND, VALVES);

  vpim_pkg::vpim_lane_state_t stQ;
  vpim_pkg::vpim_lane_state_t stD;
  logic [15:0]                masked;

  always_comb begin
    stD = stQ;
    masked = rawWord & MASK;
    if (!run) begin
      stD.drive = 16'h0000;
    end else if (KIND == vpim_pkg::KIND_WORD && swap) begin
      stD.drive = {masked[7:0], masked[15:8]};
    end else begin
      stD.drive = masked;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      stQ <= '0;
    end else begin
      stQ <= stD;
    end
  end

  assign driveWord = stQ.drive;

  a_run_low_zero: assert property (@(posedge core_clk) disable iff (!resetn)
    !run |=> driveWord == 16'h0000)
    else $error("output active while run flag clear");

  a_drive_info_only: assert property (@(posedge core_clk) disable iff (!resetn)
    (driveWord & ~MASK) == 16'h0000)
    else $error("non-information bit driven");

  a_run_high_pass: assert property (@(posedge core_clk) disable iff (!resetn)
    run && !swap |=> driveWord == ($past(rawWord) & MASK))
    else $error("payload not applied while run set");

  a_swap_order: assert property (@(posedge core_clk) disable iff (!resetn)
    run && swap && KIND == vpim_pkg::KIND_WORD
      |=> driveWord == {$past(rawWord[7:0]), $past(rawWord[15:8])})
    else $error("16-bit value not byte swapped");
endmodule

// >>> verification/vpim_plc_model.sv
// Purpose: fieldbus controller model, drives the register bus
// Assumes: slave answers with pready, single core_clk
// Notes: tasks are called from the bench top
`timescale 1ns/1ps
module vpim_plc_model (
  // clock
  input  wire logic                    core_clk,
  // register bus
  input  wire vpim_pkg::vpim_apb_rsp_t apbRsp,
  output vpim_pkg::vpim_apb_req_t      apbReq,
  // status
  output logic                         timedOut
);
  initial begin
    apbReq   = '0;
    timedOut = 1'b0;
  end

  // one transfer, held until pready seen at an edge
  task automatic xfer(input logic wr, input logic [11:0] addr, input logic [31:0] data);
    int n;
    n = 0;
    @(posedge core_clk);
    apbReq <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: addr, pwdata: data};
    @(posedge core_clk);
    apbReq.penable <= 1'b1;
    @(posedge core_clk);
    while (apbRsp.pready !== 1'b1 && n < 40) begin
      @(posedge core_clk);
      n++;
    end
    if (n >= 40) timedOut <= 1'b1;
    apbReq.psel    <= 1'b0;
    apbReq.penable <= 1'b0;
  endtask

  task automatic sendParams(input logic [15:0] p, input logic run);
    xfer(1'b1, 12'h028, {16'h0000, p});
    xfer(1'b1, 12'h000, {30'h0, run, 1'b1});
  endtask

  task automatic endParams(input logic run);
    xfer(1'b1, 12'h000, {30'h0, run, 1'b0});
  endtask
endmodule

// >>> verification/vpim_image_map_tb_top.sv
// Purpose: self-checking bench for the process image map
// Assumes: controller model drives the register bus
// Notes: read results checked from a queue by a monitor
`timescale 1ns/1ps
module vpim_image_map_tb_top;
  logic                    core_clk;
  logic                    resetn;
  vpim_pkg::vpim_apb_req_t apbReq;
  vpim_pkg::vpim_apb_rsp_t apbRsp;
  logic [3:1][15:0]        modInWords;
  logic [7:0][7:0]         diagBytes;
  logic                    paramLost;
  logic [9:1][15:0]        driveWords;
  logic [15:0]             activeParam;
  logic                    paramAck;
  logic                    irq;
  logic                    timedOut;
  int                      n_mismatch;
  int                      comparisons;
  int                      seed;
  logic [32:0]             expQ[$];
  logic [32:0]             e;
  logic [15:0]             mask [11];
  logic [15:0]             img  [11];

  vpim_image_map u_vpim_image_map (
    .core_clk    (core_clk),
    .resetn      (resetn),
    .apbReq      (apbReq),
    .apbRsp      (apbRsp),
    .modInWords  (modInWords),
    .diagBytes   (diagBytes),
    .paramLost   (paramLost),
    .driveWords  (driveWords),
    .activeParam (activeParam),
    .paramAck    (paramAck),
    .irq         (irq)
  );

  vpim_plc_model u_vpim_plc_model (
    .core_clk (core_clk),
    .apbRsp   (apbRsp),
    .apbReq   (apbReq),
    .timedOut (timedOut)
  );

  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  task automatic print_verdict();
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    u_vpim_plc_model.xfer(1'b1, a, d);
  endtask

  task automatic rd(input logic [11:0] a, input logic err, input logic [31:0] d);
    expQ.push_back({err, d});
    u_vpim_plc_model.xfer(1'b0, a, 32'h0);
  endtask

  task automatic settle();
    repeat (2) @(negedge core_clk);
  endtask

  // read monitor: oldest note against the completing read
  always @(posedge core_clk) begin
    if (apbReq.psel && apbReq.penable && apbRsp.pready === 1'b1 && !apbReq.pwrite) begin
      e = (expQ.size() > 0) ? expQ.pop_front() : ~{apbRsp.pslverr, apbRsp.prdata};
      chk({31'h0, apbRsp.pslverr}, {31'h0, e[32]});
      chk(apbRsp.prdata, e[31:0]);
    end
  end

  always @(posedge timedOut) begin
    n_mismatch++;
    print_verdict();
  end

  initial begin
    seed = 67;
    n_mismatch = 0;
    comparisons = 0;
    resetn = 1'b0;
    modInWords = '0;
    diagBytes = '0;
    paramLost = 1'b0;
    mask = '{16'h0003, 16'h00ff, 16'h000f, 16'h003f, 16'h00ff, 16'hffff,
             16'h00ff, 16'h00ff, 16'h003f, 16'h00ff, 16'h000c};
    repeat (5) @(posedge core_clk);
    resetn <= 1'b1;
    modInWords <= {16'($random(seed)), 16'($random(seed)), 16'($random(seed))};
    diagBytes <= {$random(seed), $random(seed)};
    for (int i = 0; i < 11; i++) rd(12'(4 * i), 1'b0, 32'h0);
    $display("test reset done");
    for (int i = 0; i < 11; i++) begin
      img[i] = 16'($random(seed));
      if (i == 0) img[i][1:0] = 2'b00;
      wr(12'(4 * i), {16'hffff, img[i]});
    end
    for (int i = 0; i < 11; i++) rd(12'(4 * i), 1'b0, {16'h0, img[i] & mask[i]});
    rd(12'h02c, 1'b1, 32'h0);
    rd(12'h002, 1'b1, 32'h0);
    settle();
    for (int i = 1; i < 10; i++) chk(32'(driveWords[i]), 32'h0);
    $display("test image done");
    wr(12'h000, 32'h2);
    settle();
    for (int i = 1; i < 10; i++) chk(32'(driveWords[i]), 32'(img[i] & mask[i]));
    rd(12'h044, 1'b0, {16'h0, modInWords[1]});
    for (int i = 2; i < 4; i++) rd(12'(64 + 4 * i), 1'b0, {24'h0, modInWords[i][7:0]});
    for (int i = 4; i < 8; i++) begin
      rd(12'(64 + 4 * i), 1'b0, {16'h0, diagBytes[2 * i - 7], diagBytes[2 * i - 8]});
    end
    rd(12'h060, 1'b1, 32'h0);
    $display("test run done");
    u_vpim_plc_model.sendParams(16'h000f, 1'b1);
    settle();
    chk({16'h0, activeParam}, 32'h000c);
    chk({31'h0, paramAck}, 32'h1);
    rd(12'h040, 1'b0, 32'h1);
    chk({16'h0, driveWords[5]}, {16'h0, img[5][7:0], img[5][15:8]});
    rd(12'h044, 1'b0, {16'h0, modInWords[1][7:0], modInWords[1][15:8]});
    u_vpim_plc_model.endParams(1'b1);
    @(posedge core_clk);
    paramLost <= 1'b1;
    @(posedge core_clk);
    paramLost <= 1'b0;
    settle();
    chk({31'h0, paramAck}, 32'h0);
    chk({16'h0, activeParam}, 32'h0);
    rd(12'h040, 1'b0, 32'h0);
    wr(12'h000, 32'h0);
    settle();
    for (int i = 1; i < 10; i++) chk(32'(driveWords[i]), 32'h0);
    $display("test params done");
    rd(12'h080, 1'b0, 32'h7);
    wr(12'h088, 32'h1);
    settle();
    chk({31'h0, irq}, 32'h1);
    wr(12'h084, 32'h1);
    rd(12'h080, 1'b0, 32'h6);
    settle();
    chk({31'h0, irq}, 32'h0);
    wr(12'h088, 32'h2);
    settle();
    chk({31'h0, irq}, 32'h1);
    wr(12'h088, 32'h0);
    settle();
    chk({31'h0, irq}, 32'h0);
    wr(12'h084, 32'h6);
    rd(12'h080, 1'b0, 32'h0);
    rd(12'h084, 1'b0, 32'h0);
    rd(12'h088, 1'b0, 32'h0);
    $display("test irq done");
    settle();
    print_verdict();
  end
endmodule
